// ==== src/flash_host_pkg.sv ====
// Purpose: shared constants and types of the flash command-mode host
// Assumes: 100 MHz reference clock, 16-bit flash data bus, 24-bit word address
// Notes: command encodings not fixed here are parameters of the top module
package flash_host_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int REG_AW = 8;
  // flash pin timing
  localparam int CLK_NS = 10;
  localparam int T_SETUP_NS = 20;
  localparam int T_WP_NS = 50;
  localparam int T_HOLD_NS = 20;
  localparam int T_ACCESS_NS = 120;
  // least times, rounded up to whole cycles
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACCESS_CYC = 8'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
  // software register byte offsets
  localparam logic [REG_AW-1:0] OFS_CFG = 8'h00;
  localparam logic [REG_AW-1:0] OFS_CMD = 8'h04;
  localparam logic [REG_AW-1:0] OFS_ADDR = 8'h08;
  localparam logic [REG_AW-1:0] OFS_WDATA = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_RDATA = 8'h10;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h14;
  // configuration bit positions, reset value
  localparam int CFG_SUSP_BIT = 0;
  localparam int CFG_AUTORST_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_MODE_LO = 1;
  localparam int ST_TLE = 3;
  localparam int ST_BUFABT = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_CHKERR = 6;
  localparam int ST_PROT = 7;
  localparam int ST_UNKNOWN = 8;
  // polled status bits of the flash data bus
  localparam int DQ_TLE_BIT = 5;
  localparam int DQ_BUFABT_BIT = 1;
  // query and autoselect addresses
  localparam logic [7:0] QRY_CMD_ADDR = 8'h55;
  localparam logic [7:0] QRY_CMD = 8'h98;
  localparam logic [7:0] EXT_FIRST = 8'h40;
  localparam logic [7:0] EXT_LAST = 8'h50;
  localparam logic [7:0] EXT_WP_POS = 8'h4f;
  localparam logic [7:0] AS_PROT_LOW = 8'h02;

  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_RESET = 3'h2,
    OP_QUERY = 3'h3, OP_AUTOSEL = 3'h4, OP_POLL = 3'h5
  } op_t;
  typedef enum logic [1:0] {
    MODE_ARRAY = 2'h0, MODE_ESR = 2'h1, MODE_QUERY = 2'h2, MODE_AUTOSEL = 2'h3
  } mode_t;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cyc_t;
endpackage

// ==== src/flash_cycle_if.sv ====
// Purpose: request/answer link between sequencer and pin cycle engine
// Assumes: one request outstanding at a time
// Notes: req is a one-cycle pulse, done a one-cycle pulse with rdata valid
`timescale 1ns/10ps
interface flash_cycle_if import flash_host_pkg::*; ();
  logic req;
  cyc_t cmd;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport engine(input req, input cmd, output done, output rdata);
  modport sequencer(output req, output cmd, input done, input rdata);
endinterface

// ==== src/flash_cycle_engine.sv ====
// Purpose: drives one flash read or write bus cycle on the pins
// Assumes: requests arrive only while idle
// Notes: address set before the strobe falls, data held past its rise
`timescale 1ns/10ps
module flash_cycle_engine import flash_host_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // sequencer side
  flash_cycle_if.engine cyc,
  // flash pins
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic [DATA_W-1:0] o_flash_dq_out,
  output logic o_flash_dq_oe,
  input wire logic [DATA_W-1:0] i_flash_dq_in,
  output logic o_flash_ce_n,
  output logic o_flash_we_n,
  output logic o_flash_oe_n
);
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00, PH_SETUP = 2'b01, PH_STROBE = 2'b11, PH_HOLD = 2'b10
  } phase_t;

  phase_t phase;
  logic [7:0] cnt;
  logic is_wr;
  wire cnt_zero = (cnt == 8'h00);
  wire [7:0] strobe_len = is_wr ? WP_CYC : ACCESS_CYC;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      phase <= PH_IDLE;
      cnt <= 8'h00;
      is_wr <= 1'b0;
      o_flash_addr <= '0;
      o_flash_dq_out <= '0;
      o_flash_dq_oe <= 1'b0;
      o_flash_ce_n <= 1'b1;
      o_flash_we_n <= 1'b1;
      o_flash_oe_n <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      case (phase)
        PH_IDLE: begin
          if (cyc.req) begin
            o_flash_addr <= cyc.cmd.addr;
            o_flash_dq_out <= cyc.cmd.data;
            o_flash_dq_oe <= cyc.cmd.wr;
            is_wr <= cyc.cmd.wr;
            o_flash_ce_n <= 1'b0;
            cnt <= SETUP_CYC - 8'h01;
            phase <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          if (cnt_zero) begin
            o_flash_we_n <= !is_wr;
            o_flash_oe_n <= is_wr;
            cnt <= strobe_len - 8'h01;
            phase <= PH_STROBE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        PH_STROBE: begin
          if (cnt_zero) begin
            o_flash_we_n <= 1'b1;
            o_flash_oe_n <= 1'b1;
            if (!is_wr) begin
              cyc.rdata <= i_flash_dq_in;
            end
            cnt <= HOLD_CYC - 8'h01;
            phase <= PH_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        PH_HOLD: begin
          if (cnt_zero) begin
            o_flash_ce_n <= 1'b1;
            o_flash_dq_oe <= 1'b0;
            cyc.done <= 1'b1;
            phase <= PH_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end
endmodule

// ==== src/flash_cmd_host.sv ====
// Purpose: host-side controller issuing flash command-mode sequences
// Assumes: software drives the plain register port; flash pins synchronous
// Notes: tracks device mode and checks query/autoselect answers
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module flash_cmd_host import flash_host_pkg::*; #(
  parameter logic [ADDR_W-1:0] UNLOCK1_ADDR = 24'h000555,
  parameter logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa,
  parameter logic [ADDR_W-1:0] UNLOCK2_ADDR = 24'h0002aa,
  parameter logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055,
  parameter logic [DATA_W-1:0] AUTOSEL_CMD = 16'h0090,
  parameter logic [DATA_W-1:0] RESET_CMD = 16'h00f0
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // software register port
  input wire logic [REG_AW-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // flash pins
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic [DATA_W-1:0] o_flash_dq_out,
  output logic o_flash_dq_oe,
  input wire logic [DATA_W-1:0] i_flash_dq_in,
  output logic o_flash_ce_n,
  output logic o_flash_we_n,
  output logic o_flash_oe_n
);
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00, SQ_ISSUE = 2'b01, SQ_WAIT = 2'b11
  } seq_t;

  flash_cycle_if cyc_link();

  seq_t seq;
  op_t op;
  mode_t mode;
  logic [1:0] step;
  logic [1:0] cfg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic tle_flag;
  logic bufabt_flag;
  logic refused;
  logic chk_err;
  logic prot_bit;
  logic mode_unknown;
  logic req_q;

  // sequence table: cycle idx of an operation
  function automatic cyc_t seq_cycle(input op_t o, input logic [1:0] idx,
                                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    cyc_t c;
    c = '{wr: 1'b1, addr: a, data: d};
    case (o)
      OP_READ, OP_POLL: c.wr = 1'b0;
      OP_WRITE: c = '{wr: 1'b1, addr: a, data: d};
      OP_RESET: c = '{wr: 1'b1, addr: a, data: RESET_CMD};
      OP_QUERY: c = '{wr: 1'b1, addr: {16'h0000, QRY_CMD_ADDR}, data: {8'h00, QRY_CMD}};
      OP_AUTOSEL: begin
        case (idx)
          2'd0: c = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
          2'd1: c = '{wr: 1'b1, addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
          default: c = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: AUTOSEL_CMD};
        endcase
      end
      default: c.wr = 1'b0;
    endcase
    return c;
  endfunction

  // expected extended query word: {known, value}
  function automatic logic [DATA_W:0] query_expect(input logic [7:0] a);
    case (a)
      8'h40: return {1'b1, 16'h0050};
      8'h41: return {1'b1, 16'h0052};
      8'h42: return {1'b1, 16'h0049};
      8'h43: return {1'b1, 16'h0031};
      8'h44: return {1'b1, 16'h0033};
      8'h45: return {1'b1, 16'h0010};
      8'h46: return {1'b1, 16'h0002};
      8'h47: return {1'b1, 16'h0001};
      8'h48: return {1'b1, 16'h0000};
      8'h49: return {1'b1, 16'h0008};
      8'h4a: return {1'b1, 16'h0000};
      8'h4b: return {1'b1, 16'h0000};
      8'h4c: return {1'b1, 16'h0002};
      8'h4d: return {1'b1, 16'h00b5};
      8'h4e: return {1'b1, 16'h00c5};
      8'h50: return {1'b1, 16'h0001};
      default: return {1'b0, 16'h0000};
    endcase
  endfunction

  wire [2:0] cmd_op = i_reg_wdata[2:0];
  wire cmd_wr = i_reg_wr && (i_reg_addr == OFS_CMD);
  wire busy = (seq != SQ_IDLE);
  wire [1:0] seq_len = (op == OP_AUTOSEL) ? 2'd3 : 2'd1;
  wire last_step = (step == seq_len - 2'd1);
  wire cyc_t cur_cyc = seq_cycle(op, step, addr_reg, wdata_reg);
  // autoselect only from read modes; query from array read or autoselect
  wire mode_refuse = ((cmd_op == OP_AUTOSEL) && !(mode == MODE_ARRAY || mode == MODE_ESR)) ||
                     ((cmd_op == OP_QUERY) && !(mode == MODE_ARRAY || mode == MODE_AUTOSEL));
  // only raw writes or reset while buffer abort pending
  wire abort_refuse = bufabt_flag && (cmd_op != OP_WRITE) && (cmd_op != OP_RESET);
  wire bad_op = (cmd_op > 3'(OP_POLL));
  wire start_ok = cmd_wr && !busy && !mode_refuse && !abort_refuse && !bad_op;
  wire start_bad = cmd_wr && (busy || mode_refuse || abort_refuse || bad_op);
  wire fin = (seq == SQ_WAIT) && cyc_link.done;
  wire seq_done = fin && last_step;
  wire [DATA_W-1:0] rd_now = cyc_link.rdata;
  wire [7:0] lo_addr = addr_reg[7:0];
  wire [DATA_W:0] qexp = query_expect(lo_addr);
  wire in_ext = (lo_addr >= EXT_FIRST) && (lo_addr <= EXT_LAST);
  // write-protect position has two legal values
  wire wp_ok = (rd_now == 16'h0004) || (rd_now == 16'h0005);
  wire q_bad = in_ext && ((lo_addr == EXT_WP_POS) ? !wp_ok : (qexp[DATA_W] && rd_now != qexp[DATA_W-1:0]));
  wire prot_read = (mode == MODE_AUTOSEL) && (lo_addr == AS_PROT_LOW);
  // protection answer is 00h or 01h
  wire p_bad = prot_read && (rd_now[DATA_W-1:1] != 15'h0000);
  wire hi_bad = (mode == MODE_QUERY || mode == MODE_AUTOSEL) && (rd_now[15:8] != 8'h00);
  wire chk_hit = seq_done && (op == OP_READ) && (((mode == MODE_QUERY) && q_bad) || p_bad || hi_bad);
  wire tle_hit = seq_done && (op == OP_POLL) && rd_now[DQ_TLE_BIT];
  wire abt_hit = seq_done && (op == OP_POLL) && rd_now[DQ_BUFABT_BIT];
  // timeout chains a reset when enabled
  wire chain_reset = tle_hit && cfg[CFG_AUTORST_BIT];
  wire st_w1c = i_reg_wr && (i_reg_addr == OFS_STATUS);
  wire [31:0] status_word = {23'h0, mode_unknown, prot_bit, chk_err, refused, bufabt_flag, tle_flag, mode, busy};
  wire [31:0] rd_mux = (i_reg_addr == OFS_CFG) ? {30'h0, cfg} :
                       (i_reg_addr == OFS_ADDR) ? {8'h00, addr_reg} :
                       (i_reg_addr == OFS_WDATA) ? {16'h0000, wdata_reg} :
                       (i_reg_addr == OFS_RDATA) ? {16'h0000, rdata_reg} :
                       (i_reg_addr == OFS_STATUS) ? status_word : 32'h0000_0000;
  // reset lands in suspend-read when an erase is suspended
  wire mode_t reset_mode = cfg[CFG_SUSP_BIT] ? MODE_ESR : MODE_ARRAY;

  assign cyc_link.req = req_q;
  assign cyc_link.cmd = cur_cyc;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      cfg <= CFG_RESET;
      addr_reg <= '0;
      wdata_reg <= '0;
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      if (i_reg_wr && i_reg_addr == OFS_CFG) cfg <= i_reg_wdata[1:0];
      if (i_reg_wr && i_reg_addr == OFS_ADDR) addr_reg <= i_reg_wdata[ADDR_W-1:0];
      if (i_reg_wr && i_reg_addr == OFS_WDATA) wdata_reg <= i_reg_wdata[DATA_W-1:0];
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // sequencer
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      seq <= SQ_IDLE;
      op <= OP_READ;
      step <= 2'd0;
      req_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      case (seq)
        SQ_IDLE: begin
          if (start_ok) begin
            op <= op_t'(cmd_op);
            step <= 2'd0;
            seq <= SQ_ISSUE;
          end
        end
        SQ_ISSUE: begin
          req_q <= 1'b1;
          seq <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (chain_reset) begin
            op <= OP_RESET;
            step <= 2'd0;
            seq <= SQ_ISSUE;
          end else if (seq_done) begin
            seq <= SQ_IDLE;
          end else if (fin) begin
            step <= step + 2'd1;
            seq <= SQ_ISSUE;
          end
        end
        default: seq <= SQ_IDLE;
      endcase
    end
  end

  // mode tracking and sticky flags; a set beats a same-cycle clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      mode <= MODE_ARRAY;
      mode_unknown <= 1'b0;
      rdata_reg <= '0;
      prot_bit <= 1'b0;
    end else if (seq_done) begin
      case (op)
        OP_READ, OP_POLL: rdata_reg <= rd_now;
        OP_RESET: begin
          mode <= reset_mode;
          mode_unknown <= 1'b0;
        end
        OP_QUERY: mode <= MODE_QUERY;
        OP_AUTOSEL: mode <= MODE_AUTOSEL;
        // raw writes leave the device state untracked
        OP_WRITE: mode_unknown <= 1'b1;
        default: mode_unknown <= 1'b1;
      endcase
      if (prot_read && op == OP_READ) prot_bit <= rd_now[0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      tle_flag <= 1'b0;
      bufabt_flag <= 1'b0;
      refused <= 1'b0;
      chk_err <= 1'b0;
    end else begin
      tle_flag <= tle_hit || (tle_flag && !(st_w1c && i_reg_wdata[ST_TLE]));
      bufabt_flag <= abt_hit || (bufabt_flag && !(st_w1c && i_reg_wdata[ST_BUFABT]));
      refused <= start_bad || (refused && !(st_w1c && i_reg_wdata[ST_REFUSED]));
      chk_err <= chk_hit || (chk_err && !(st_w1c && i_reg_wdata[ST_CHKERR]));
    end
  end

  flash_cycle_engine u_engine (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .cyc(cyc_link.engine),
    .o_flash_addr(o_flash_addr),
    .o_flash_dq_out(o_flash_dq_out),
    .o_flash_dq_oe(o_flash_dq_oe),
    .i_flash_dq_in(i_flash_dq_in),
    .o_flash_ce_n(o_flash_ce_n),
    .o_flash_we_n(o_flash_we_n),
    .o_flash_oe_n(o_flash_oe_n)
  );
endmodule

// ==== testbench/flash_host_asserts.sv ====
// Purpose: pin timing and register port checks of the flash host
// Assumes: default pin timing of the package
// Notes: sees only the top-level ports
`timescale 1ns/10ps
module flash_host_asserts import flash_host_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [REG_AW-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  // flash pins
  input wire logic [ADDR_W-1:0] o_flash_addr,
  input wire logic [DATA_W-1:0] o_flash_dq_out,
  input wire logic o_flash_dq_oe,
  input wire logic [DATA_W-1:0] i_flash_dq_in,
  input wire logic o_flash_ce_n,
  input wire logic o_flash_we_n,
  input wire logic o_flash_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr > OFS_STATUS |=> o_reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_pins_idle: assert property ($rose(i_reset_n) |-> o_flash_ce_n && o_flash_we_n && o_flash_oe_n && !o_flash_dq_oe)
    else $error("pins not idle after reset");
  a_write_select: assert property (!o_flash_we_n |-> !o_flash_ce_n && o_flash_oe_n && o_flash_dq_oe)
    else $error("write strobe outside select");
  a_addr_setup: assert property ($fell(o_flash_we_n) |-> $past(o_flash_ce_n, 2) == 1'b0 && $stable(o_flash_addr))
    else $error("address setup short");
  a_strobe_width: assert property ($fell(o_flash_we_n) |-> o_flash_we_n == 1'b0 [*5] ##1 o_flash_we_n)
    else $error("write pulse width wrong");
  a_data_hold: assert property ($rose(o_flash_we_n) |->
    (!o_flash_ce_n && o_flash_dq_oe && $stable(o_flash_dq_out)) [*2] ##1 o_flash_ce_n)
    else $error("data hold wrong");
  a_read_no_drive: assert property (!o_flash_oe_n |-> !o_flash_dq_oe && !o_flash_ce_n && o_flash_we_n)
    else $error("bus driven during read");
  a_read_access: assert property ($fell(o_flash_oe_n) |->
    !o_flash_oe_n [*8] ##1 !o_flash_oe_n [*4] ##1 o_flash_oe_n)
    else $error("read access time wrong");
endmodule

// ==== testbench/flash_dev_model.sv ====
// Purpose: behavioural flash die answering query and autoselect reads
// Assumes: no embedded program or erase is modelled
// Notes: a released bus shows the inverse of the answer, never a held value
`timescale 1ns/10ps
module flash_dev_model import flash_host_pkg::*; #(
  parameter logic [15:0] MFR_CODE = 16'h00a5, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h007e, // arbitrary value
  parameter logic [15:0] WP_POS = 16'h0004
) (
  // flash pins
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  output logic [DATA_W-1:0] o_dq,
  // test controls
  input wire logic i_tle,
  input wire logic i_bad,
  output logic [1:0] o_mode,
  output logic [7:0] o_resets
);
  logic [15:0] qt [17] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033, 16'h0010, 16'h0002, 16'h0001,
    16'h0000, 16'h0008, 16'h0000, 16'h0000, 16'h0002, 16'h00b5, 16'h00c5, WP_POS, 16'h0001};
  logic [ADDR_W-1:0] lat_a;
  logic [1:0] ul;
  logic [15:0] rv;
  wire wsel = i_ce_n | i_we_n;
  // answers by mode: array mode returns the low address bits with i_tle on bit 5, query and autoselect answers have upper byte zero unless i_bad in autoselect
  always_comb begin
    rv = i_addr[15:0] | (i_tle ? 16'h0020 : 16'h0);
    if (o_mode == 2'h1) begin
      rv = (i_addr[7:0] >= 8'h40 && i_addr[7:0] <= 8'h50) ? qt[i_addr[7:0] - 8'h40] : 16'h0;
      if (i_bad && i_addr[7:0] == 8'h45) rv = 16'h0011;
    end
    if (o_mode == 2'h2) begin
      case (i_addr[7:0])
        8'h00: rv = MFR_CODE;
        8'h01: rv = DEV_CODE;
        8'h0e: rv = DEV_CODE + 16'h1;
        8'h0f: rv = DEV_CODE + 16'h2;
        8'h02: rv = {15'h0, i_addr[16]};
        default: rv = 16'h0;
      endcase
      // faulty answer to reach the host's checks
      if (i_bad) rv = rv | 16'h0100;
    end
  end
  assign o_dq = (!i_ce_n && !i_oe_n) ? rv : ~rv;
  // address at the later falling strobe
  always @(negedge wsel) lat_a <= i_addr;
  initial begin
    o_mode = 2'h0;
    ul = 2'h0;
    o_resets = 8'h0;
  end
  // decode at the earlier rising strobe
  always @(posedge wsel) begin
    ul <= 2'h0;
    if (i_dq[7:0] == 8'hf0) begin
      o_mode <= 2'h0;
      o_resets <= o_resets + 8'h1;
    end else if (i_tle) begin
      ul <= 2'h0;
    end else if (i_dq[7:0] == 8'haa && lat_a[11:0] == 12'h555) ul <= 2'h1;
    else if (i_dq[7:0] == 8'h55 && lat_a[11:0] == 12'h2aa && ul == 2'h1) ul <= 2'h2;
    else if (i_dq[7:0] == 8'h90 && lat_a[11:0] == 12'h555 && ul == 2'h2 && o_mode == 2'h0) o_mode <= 2'h2;
    else if (i_dq[7:0] == 8'h98 && lat_a[7:0] == 8'h55 && o_mode != 2'h1) o_mode <= 2'h1;
  end
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the flash command-mode host
// Assumes: default unlock encodings and pin timing
// Notes: device answers come from a behavioural model
`timescale 1ns/10ps
module tb_top import flash_host_pkg::*;;
  localparam logic [15:0] MFR = 16'h00a5; // arbitrary value
  localparam logic [15:0] DEV = 16'h007e; // arbitrary value
  localparam logic [31:0] M = 32'h17f;
  logic i_ref_clk = 1'b0;
  logic i_reset_n, i_reg_wr, i_reg_rd, doe, ce_n, we_n, oe_n, tle, bad;
  logic [REG_AW-1:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, v;
  logic [ADDR_W-1:0] fa;
  logic [DATA_W-1:0] fdo, fdm;
  logic [1:0] dmode;
  logic [7:0] dres, r0;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] qt [17] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033, 16'h0010, 16'h0002, 16'h0001,
    16'h0000, 16'h0008, 16'h0000, 16'h0000, 16'h0002, 16'h00b5, 16'h00c5, 16'h0004, 16'h0001};
  logic [23:0] as_a [6] = '{24'h0, 24'h1, 24'he, 24'hf, 24'h2, 24'h10002};
  logic [15:0] as_d [6] = '{MFR, DEV, DEV + 16'h1, DEV + 16'h2, 16'h0, 16'h1};
  // wire level from the host's enable; the model drives it otherwise
  wire [DATA_W-1:0] dq_w = doe ? fdo : fdm;

  always #5 i_ref_clk = ~i_ref_clk;

  flash_cmd_host dut_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_flash_addr(fa), .o_flash_dq_out(fdo), .o_flash_dq_oe(doe), .i_flash_dq_in(dq_w),
    .o_flash_ce_n(ce_n), .o_flash_we_n(we_n), .o_flash_oe_n(oe_n));
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev_u (.i_addr(fa), .i_dq(dq_w), .i_ce_n(ce_n),
    .i_we_n(we_n), .i_oe_n(oe_n), .o_dq(fdm), .i_tle(tle), .i_bad(bad), .o_mode(dmode), .o_resets(dres));

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_ref_clk);
    v = o_reg_rdata;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    reg_rd(a);
    check(n, v & m, e);
  endtask
  task automatic cmd(input op_t op, input logic [23:0] a);
    int i;
    reg_wr(OFS_ADDR, {8'h0, a});
    reg_wr(OFS_CMD, {29'h0, op});
    for (i = 0; i < 40 && (i == 0 || v[ST_BUSY] !== 1'b0); i++) reg_rd(OFS_STATUS);
    check("busy", {31'h0, v[ST_BUSY]}, 32'h0);
  endtask
  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard, the run needs under two thousand cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done;
    end
  end

  initial begin
    int i;
    i_reset_n = 1'b0;
    i_reg_addr = 8'h0;
    i_reg_wdata = 32'h0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    tle = 1'b0;
    bad = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    rd_chk("status", OFS_STATUS, 32'h0, '1);
    rd_chk("cfg", OFS_CFG, 32'h0, '1);
    rd_chk("unmapped", 8'h40, 32'h0, '1);
    cmd(OP_QUERY, 24'h0);
    rd_chk("query mode", OFS_STATUS, 32'h4, M);
    for (i = 0; i < 17; i++) begin
      cmd(OP_READ, 24'(32'h40 + i));
      rd_chk("query word", OFS_RDATA, {16'h0, qt[i]}, '1);
    end
    rd_chk("query clean", OFS_STATUS, 32'h4, M);
    bad = 1'b1;
    cmd(OP_READ, 24'h45);
    rd_chk("bad word", OFS_STATUS, 32'h44, M);
    bad = 1'b0;
    reg_wr(OFS_STATUS, 32'h40);
    cmd(OP_RESET, 24'h123456);
    rd_chk("reset mode", OFS_STATUS, 32'h0, M);
    check("dev mode", {30'h0, dmode}, 32'h0);
    cmd(OP_AUTOSEL, 24'h0);
    check("dev mode", {30'h0, dmode}, 32'h2);
    for (i = 0; i < 6; i++) begin
      cmd(OP_READ, as_a[i]);
      rd_chk("autoselect word", OFS_RDATA, {16'h0, as_d[i]}, '1);
    end
    rd_chk("protected", OFS_STATUS, 32'h86, '1);
    bad = 1'b1;
    cmd(OP_READ, 24'h2);
    rd_chk("bad autoselect", OFS_STATUS, 32'h46, M);
    bad = 1'b0;
    reg_wr(OFS_STATUS, 32'h40);
    cmd(OP_AUTOSEL, 24'h0);
    rd_chk("refused", OFS_STATUS, 32'h26, M);
    reg_wr(OFS_STATUS, 32'h20);
    cmd(OP_QUERY, 24'h0);
    check("dev mode", {30'h0, dmode}, 32'h1);
    reg_wr(OFS_CFG, 32'h1);
    cmd(OP_RESET, 24'h0);
    rd_chk("suspend read", OFS_STATUS, 32'h2, M);
    cmd(OP_READ, 24'h1234);
    rd_chk("suspend array", OFS_RDATA, 32'h1234, '1);
    cmd(OP_QUERY, 24'h0);
    rd_chk("refused", OFS_STATUS, 32'h22, M);
    reg_wr(OFS_STATUS, 32'h20);
    cmd(OP_AUTOSEL, 24'h0);
    rd_chk("autoselect", OFS_STATUS, 32'h6, M);
    cmd(OP_RESET, 24'h0);
    rd_chk("back to suspend", OFS_STATUS, 32'h2, M);
    reg_wr(OFS_CFG, 32'h2);
    cmd(OP_RESET, 24'h0);
    tle = 1'b1;
    r0 = dres;
    cmd(OP_POLL, 24'h0);
    tle = 1'b0;
    rd_chk("time limit", OFS_STATUS, 32'h8, M);
    check("auto reset", {24'h0, dres}, {24'h0, r0 + 8'h1});
    reg_wr(OFS_STATUS, 32'h8);
    reg_wr(OFS_CMD, 32'h6);
    rd_chk("bad op", OFS_STATUS, 32'h20, M);
    reg_wr(OFS_STATUS, 32'h20);
    reg_wr(OFS_CMD, {29'h0, OP_READ});
    cmd(OP_READ, 24'h0);
    rd_chk("busy refused", OFS_STATUS, 32'h20, M);
    reg_wr(OFS_STATUS, 32'h20);
    cmd(OP_POLL, 24'h2);
    rd_chk("buffer abort", OFS_STATUS, 32'h10, M);
    cmd(OP_QUERY, 24'h0);
    rd_chk("abort refused", OFS_STATUS, 32'h30, M);
    reg_wr(OFS_STATUS, 32'h30);
    reg_wr(OFS_WDATA, 32'haa);
    cmd(OP_WRITE, 24'h555);
    rd_chk("unknown", OFS_STATUS, 32'h100, M);
    cmd(OP_RESET, 24'h0);
    rd_chk("recovered", OFS_STATUS, 32'h0, M);
    check("dev mode", {30'h0, dmode}, 32'h0);
    test_done;
  end
endmodule

bind flash_cmd_host flash_host_asserts chk_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_flash_addr(o_flash_addr), .o_flash_dq_out(o_flash_dq_out),
  .o_flash_dq_oe(o_flash_dq_oe), .i_flash_dq_in(i_flash_dq_in), .o_flash_ce_n(o_flash_ce_n),
  .o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n));
